// file: sim/hsfp_host_model.sv
/*
 * Host CPU and DMA controller model on the slave bus.
 * Assumes the testbench calls access; strobes change 2 ns after clk.
 */
`timescale 1ns/1ns
`default_nettype none

module hsfp_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] dOut,
    input  wire logic       oe,
    output logic            csN,
    output logic      [2:0] addr,
    output logic            rdN,
    output logic            wrN,
    output logic            dackN,
    output logic      [7:0] busIn
);
    logic       drv;
    logic [7:0] drvVal;
    logic [7:0] lastBus;
    // Floating bus shows the inverse of its last level
    assign busIn = oe ? dOut : (drv ? drvVal : ~lastBus);
    always @(posedge clk) lastBus <= busIn;
    initial begin
        csN = 1'b1;
        dackN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        addr = 3'h0;
        drv = 1'b0;
        drvVal = 8'h00;
        lastBus = 8'h00;
    end
    // ------------------------------------------------------------
    // One bus cycle; strobe low 7 clocks, data held 6 after
    // ------------------------------------------------------------
    task automatic access(input logic wr, cs, host_dma_ack, input logic [2:0] a, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(posedge clk);
        #2;
        csN = !cs;
        dackN = !host_dma_ack;
        addr = a;
        drv = wr;
        drvVal = wd;
        rdN = wr;
        wrN = !wr;
        repeat (7) @(posedge clk);
        rd = busIn;
        #2;
        rdN = 1'b1;
        wrN = 1'b1;
        csN = 1'b1;
        dackN = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        drv = 1'b0;
        repeat (2) @(posedge clk);
        #2;
    endtask
endmodule

`default_nettype wire

// file: sim/hsfp_host_props.sv
/*
 * Checker of the host slave port, watching the top module's pins.
 * Assumes a bind to the top module; one clock, async active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none

module hsfp_host_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic hostCsN,
    input wire logic hostRdN,
    input wire logic hostWrN,
    input wire logic hostDmaAckN,
    input wire logic hostDataOe,
    input wire logic inXferDmaReq,
    input wire logic outXferDmaReq,
    input wire logic hostIrq,
    input wire logic inFifoPush,
    input wire logic immInPush,
    input wire logic outFifoPop,
    input wire logic outFifoCmd,
    input wire logic outFifoEmpty,
    input wire logic inSvcReq,
    input wire logic outSvcReq,
    input wire logic immOutValid,
    input wire logic errEvent,
    input wire logic hostDmaEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence s_dsc_head;
        hostDmaEn && outFifoCmd && !outFifoEmpty;
    endsequence
    // Seven quiet cycles outlast the pin synchroniser
    sequence s_pins_idle;
        (hostCsN && hostDmaAckN)[*7];
    endsequence
    property p_in_req; inXferDmaReq |-> $past(inSvcReq); endproperty
    a_in_req: assert property (p_in_req) else $error("input request without need");
    property p_out_req; outXferDmaReq |-> $past(outSvcReq); endproperty
    a_out_req: assert property (p_out_req) else $error("output request without need");
    property p_dsc_irq; s_dsc_head |=> hostIrq && !outXferDmaReq; endproperty
    a_dsc_irq: assert property (p_dsc_irq) else $error("command at head not flagged");
    property p_imm_irq; immOutValid |=> hostIrq; endproperty
    a_imm_irq: assert property (p_imm_irq) else $error("pending command not flagged");
    property p_err_irq; errEvent |-> ##[1:2] hostIrq; endproperty
    a_err_irq: assert property (p_err_irq) else $error("error not flagged");
    property p_desel;
        s_pins_idle |-> !hostDataOe && !inFifoPush && !immInPush && !outFifoPop;
    endproperty
    a_desel: assert property (p_desel) else $error("activity while deselected");
    property p_push_one; inFifoPush |=> !inFifoPush; endproperty
    a_push_one: assert property (p_push_one) else $error("push longer than one cycle");
    property p_push_end; inFifoPush |-> $past(hostWrN) && $past(hostWrN, 2); endproperty
    a_push_end: assert property (p_push_end) else $error("push before strobe end");
    property p_pop_end;
        outFifoPop |-> !hostDataOe && $past(hostRdN) && $past(hostRdN, 2);
    endproperty
    a_pop_end: assert property (p_pop_end) else $error("pop before read end");
    property p_rd_start;
        $rose(hostDataOe) |-> !$past(hostRdN, 3) && (!$past(hostCsN, 3) || !$past(hostDmaAckN, 3));
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("bus driven without read");
    property p_reset;
        disable iff (1'b0) rst |-> !hostDataOe && !hostIrq && !inXferDmaReq && !outXferDmaReq && !hostDmaEn;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active in reset");
endmodule

bind hsfp_host_slave_fifo_port hsfp_host_props u_hsfp_host_props (.clk, .rst, .hostCsN, .hostRdN,
    .hostWrN, .hostDmaAckN, .hostDataOe, .inXferDmaReq, .outXferDmaReq, .hostIrq, .inFifoPush,
    .immInPush, .outFifoPop, .outFifoCmd, .outFifoEmpty, .inSvcReq, .outSvcReq, .immOutValid,
    .errEvent, .hostDmaEn);

`default_nettype wire

// file: sim/testbench.sv
/*
 * Self-checking bench of the host slave FIFO port.
 * Assumes the host model on the bus and direct drive of FIFO-side inputs.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hsfp_cfg.svh"

module testbench;
    logic clk, rst, hostCsN, hostRdN, hostWrN, hostDmaAckN, hostDataOe, inXferDmaReq;
    logic outXferDmaReq, hostIrq, inFifoPush, inFifoCmd, inFifoFull, outFifoPop, outFifoCmd;
    logic outFifoEmpty, inSvcReq, outSvcReq, immInPush, immOutValid, immOutAck, errEvent, hostDmaEn;
    logic [2:0] hostAddr;
    logic [7:0] hostDataIn, hostDataOut, inFifoData, outFifoData, immInData, immOutData, rdv, immVal;
    logic [8:0] pushVal;
    logic       oeSeen;
    int         miscompares, check_count, pushCnt, immCnt, popCnt, ackCnt;

    hsfp_host_slave_fifo_port u_hsfp_host_slave_fifo_port (.clk, .rst, .hostCsN, .hostAddr, .hostRdN,
        .hostWrN, .hostDmaAckN, .hostDataIn, .hostDataOut, .hostDataOe, .inXferDmaReq, .outXferDmaReq,
        .hostIrq, .inFifoPush, .inFifoData, .inFifoCmd, .inFifoFull, .outFifoPop, .outFifoData,
        .outFifoCmd, .outFifoEmpty, .inSvcReq, .outSvcReq, .immInPush, .immInData, .immOutValid,
        .immOutData, .immOutAck, .errEvent, .hostDmaEn);
    hsfp_host_model u_hsfp_host_model (.clk, .dOut(hostDataOut), .oe(hostDataOe), .csN(hostCsN),
        .addr(hostAddr), .rdN(hostRdN), .wrN(hostWrN), .dackN(hostDmaAckN), .busIn(hostDataIn));

    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (inFifoPush) begin
            pushCnt++;
            pushVal = {inFifoCmd, inFifoData};
        end
        if (immInPush) begin
            immCnt++;
            immVal = immInData;
        end
        popCnt += int'(outFifoPop);
        ackCnt += int'(immOutAck);
        if (hostDataOe) oeSeen = 1'b1;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic acc(input logic wr, cs, host_dma_ack, input logic [2:0] a, input logic [7:0] d);
        u_hsfp_host_model.access(wr, cs, host_dma_ack, a, d, rdv);
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fifo_write;
        acc(1, 1, 0, 3'h0, 8'hA5); chk(pushVal, 9'h0A5);
        acc(1, 1, 0, 3'h1, 8'h3C); chk(pushVal, 9'h13C);
        acc(1, 0, 1, 3'h2, 8'h77); chk(pushVal, 9'h077);
        chk(pushCnt, 3);
        chk(immCnt, 0);
    endtask
    task automatic t_imm;
        acc(1, 1, 0, 3'h2, 8'h5A); chk(immVal, 8'h5A);
        chk(immCnt, 1);
        immOutValid = 1'b1;
        immOutData = 8'hC3;
        cyc(2); chk(hostIrq, 1);
        acc(0, 1, 0, 3'h2, 8'h00); chk(rdv, 8'hC3);
        chk(ackCnt, 1);
        immOutValid = 1'b0;
        cyc(2); chk(hostIrq, 0);
    endtask
    task automatic t_ctrl_req;
        acc(1, 1, 0, 3'h3, 8'h03); chk(hostDmaEn, 1);
        inSvcReq = 1'b1;
        outSvcReq = 1'b1;
        cyc(2); chk({inXferDmaReq, outXferDmaReq, hostIrq}, 3'b110);
        outFifoCmd = 1'b1;
        cyc(2); chk({outXferDmaReq, hostIrq}, 2'b01);
        acc(0, 1, 0, 3'h3, 8'h00); chk(rdv, 8'h4B);
        outFifoCmd = 1'b0;
        cyc(2);
    endtask
    task automatic t_read;
        outFifoData = 8'h96;
        acc(0, 1, 0, 3'h0, 8'h00); chk(rdv, 8'h96);
        outFifoData = 8'h69;
        acc(0, 0, 1, 3'h3, 8'h00); chk(rdv, 8'h69);
        chk(popCnt, 2);
    endtask
    task automatic t_nodma_irq;
        acc(1, 1, 0, 3'h3, 8'h00);
        chk({inXferDmaReq, outXferDmaReq, hostIrq}, 3'b001);
        inSvcReq = 1'b0;
        outSvcReq = 1'b0;
        cyc(2); chk(hostIrq, 0);
    endtask
    // Empty read and internal fault both raise the error flag
    task automatic t_err;
        outFifoEmpty = 1'b1;
        acc(0, 1, 0, 3'h0, 8'h00); chk(popCnt, 2);
        chk(hostIrq, 1);
        acc(1, 1, 0, 3'h3, 8'h80); chk(hostIrq, 0);
        outFifoEmpty = 1'b0;
        // Full input FIFO refuses the push and flags an error
        inFifoFull = 1'b1;
        acc(1, 0, 1, 3'h0, 8'h11); chk(pushCnt, 3);
        chk(hostIrq, 1);
        inFifoFull = 1'b0;
        outFifoCmd = 1'b1;
        acc(1, 1, 0, 3'h3, 8'h80); chk(hostIrq, 0);
        // Acknowledged read with command at head: byte out, no pop
        acc(0, 0, 1, 3'h0, 8'h00); chk(rdv, 8'h69);
        chk({popCnt[3:0], hostIrq}, 5'h05);
        outFifoCmd = 1'b0;
        acc(1, 1, 0, 3'h3, 8'h80); chk(hostIrq, 0);
        errEvent = 1'b1;
        cyc(1);
        errEvent = 1'b0;
        cyc(2); chk(hostIrq, 1);
        acc(1, 1, 0, 3'h3, 8'h80); chk(hostIrq, 0);
    endtask
    task automatic t_desel;
        oeSeen = 1'b0;
        acc(1, 0, 0, 3'h0, 8'hEE);
        acc(0, 0, 0, 3'h0, 8'h00);
        chk(pushCnt, 3);
        chk(popCnt, 2);
        chk(oeSeen, 0);
    endtask
    task automatic t_reset;
        acc(1, 1, 0, 3'h3, 8'h01); chk(hostDmaEn, 1);
        rst = 1'b1;
        cyc(`HSFP_RST_CLKS);
        rst = 1'b0;
        cyc(2); chk({hostDmaEn, hostDataOe, hostIrq}, 3'b000);
        acc(1, 1, 0, 3'h0, 8'h42); chk(pushVal, 9'h042);
    endtask

    initial begin
        {clk, inFifoFull, outFifoCmd, outFifoEmpty, inSvcReq, outSvcReq, immOutValid, errEvent} = '0;
        {outFifoData, immOutData, immVal, pushVal, oeSeen} = '0;
        {miscompares, check_count, pushCnt, immCnt, popCnt, ackCnt} = '0;
        // Full reset length, not a short pulse
        rst = 1'b1;
        cyc(`HSFP_RST_CLKS);
        rst = 1'b0;
        cyc(2);
        t_fifo_write();
        t_imm();
        t_ctrl_req();
        t_read();
        t_nodma_irq();
        t_err();
        t_desel();
        t_reset();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule

`default_nettype wire

// file: verilog/hsfp_cfg.svh
/*
 * Constants of the host slave FIFO port: host addresses, control and
 * status bit positions, reset values and reset timing.
 * Assumes inclusion by bare name from modules; the package does not include it.
 */
`ifndef HSFP_CFG_SVH
`define HSFP_CFG_SVH

// ----------------------------------------------------------------
// Host address map
// ----------------------------------------------------------------
`define HSFP_ADDR_FIFO    3'h0
`define HSFP_ADDR_DSC     3'h1
`define HSFP_ADDR_IMM     3'h2
`define HSFP_ADDR_CTRL    3'h3
`define HSFP_UNMAPPED_RD  8'h00

// ----------------------------------------------------------------
// Host control register
// ----------------------------------------------------------------
`define HSFP_CTRL_RESET   8'h00
`define HSFP_CTRL_DMAEN   0
`define HSFP_CTRL_REQLN   1
`define HSFP_CTRL_ERRCLR  7

// ----------------------------------------------------------------
// Host status register
// ----------------------------------------------------------------
`define HSFP_ST_INREQ     0
`define HSFP_ST_OUTREQ    1
`define HSFP_ST_IMMOUT    2
`define HSFP_ST_DSCHEAD   3
`define HSFP_ST_OUTEMPTY  4
`define HSFP_ST_INFULL    5
`define HSFP_ST_DMAEN     6
`define HSFP_ST_ERR       7

// ----------------------------------------------------------------
// Reset timing
// ----------------------------------------------------------------
`define HSFP_OSC_PER_MC   12
`define HSFP_RST_MC       2
`define HSFP_RST_CLKS     (`HSFP_OSC_PER_MC * `HSFP_RST_MC)

`endif

// file: verilog/hsfp_host_slave_fifo_port.sv
/*
 * Host side slave port: host strobes and address lines move bytes
 * into the input FIFO and out of the output FIFO, plus immediate
 * commands, a host control and a host status register.
 * Assumes FIFO storage, thresholds and the internal CPU are outside;
 * host pins are asynchronous and the data pin is split in/out/oe.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hsfp_cfg.svh"


module hsfp_host_slave_fifo_port
    import hsfp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       hostCsN,
    input  wire logic [2:0] hostAddr,
    input  wire logic       hostRdN,
    input  wire logic       hostWrN,
    input  wire logic       hostDmaAckN,
    input  wire logic [7:0] hostDataIn,
    output logic      [7:0] hostDataOut,
    output logic            hostDataOe,
    output logic            inXferDmaReq,
    output logic            outXferDmaReq,
    output logic            hostIrq,
    output logic            inFifoPush,
    output logic      [7:0] inFifoData,
    output logic            inFifoCmd,
    input  wire logic       inFifoFull,
    output logic            outFifoPop,
    input  wire logic [7:0] outFifoData,
    input  wire logic       outFifoCmd,
    input  wire logic       outFifoEmpty,
    input  wire logic       inSvcReq,
    input  wire logic       outSvcReq,
    output logic            immInPush,
    output logic      [7:0] immInData,
    input  wire logic       immOutValid,
    input  wire logic [7:0] immOutData,
    output logic            immOutAck,
    input  wire logic       errEvent,
    output logic            hostDmaEn
);

    // ------------------------------------------------------------
    // Synchronised host pins
    // ------------------------------------------------------------
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic       dackN;
    logic [2:0] addr;
    logic [7:0] busIn;

    hsfp_pin_sync #(
        .W     (4),
        .RST_V (4'hF)
    ) u_strobe_sync (
        .clk    (clk),
        .rst    (rst),
        .pinIn  ({hostCsN, hostRdN, hostWrN, hostDmaAckN}),
        .pinOut ({csN, rdN, wrN, dackN})
    );

    hsfp_pin_sync #(
        .W     (11),
        .RST_V (11'h000)
    ) u_bus_sync (
        .clk    (clk),
        .rst    (rst),
        .pinIn  ({hostAddr, hostDataIn}),
        .pinOut ({addr, busIn})
    );

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    logic selected;
    logic rdActive;
    logic wrActive;

    // Strobes only count while chip select or acknowledge is low
    assign selected = !csN || !dackN;
    assign rdActive = selected && !rdN;
    assign wrActive = selected && !wrN;

    // ------------------------------------------------------------
    // Host control register and derived modes
    // ------------------------------------------------------------
    hsfp_byte_t ctrl;
    logic       reqLinesEn;
    logic       dscAtHead;
    logic       errFlag;

    assign hostDmaEn  = ctrl[`HSFP_CTRL_DMAEN];
    assign reqLinesEn = ctrl[`HSFP_CTRL_REQLN];
    assign dscAtHead  = !outFifoEmpty && outFifoCmd;

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    hsfp_acc_e  accState;
    hsfp_acc_e  next_accState;
    logic [2:0] accAddr;
    logic       accDack;
    hsfp_byte_t wrByte;
    logic       rdEnd;
    logic       wrEnd;

    always_comb begin
        next_accState = accState;
        case (accState)
            HSFP_ACC_IDLE: begin
                if (rdActive) begin
                    next_accState = HSFP_ACC_READ;
                end else if (wrActive) begin
                    next_accState = HSFP_ACC_WRITE;
                end
            end
            HSFP_ACC_READ: begin
                if (!rdActive) begin
                    next_accState = HSFP_ACC_IDLE;
                end
            end
            HSFP_ACC_WRITE: begin
                if (!wrActive) begin
                    next_accState = HSFP_ACC_IDLE;
                end
            end
            default: begin
                next_accState = HSFP_ACC_IDLE;
            end
        endcase
    end

    assign rdEnd = (accState == HSFP_ACC_READ) && !rdActive;
    assign wrEnd = (accState == HSFP_ACC_WRITE) && !wrActive;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accState <= HSFP_ACC_IDLE;
        end else begin
            accState <= next_accState;
        end
    end

    // Address and acknowledge frozen at the leading strobe edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accAddr <= 3'h0;
            accDack <= 1'b0;
        end else if (accState == HSFP_ACC_IDLE) begin
            accAddr <= addr;
            accDack <= !dackN;
        end
    end

    // Write byte tracks the bus until the trailing edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrByte <= 8'h00;
        end else if (wrActive) begin
            wrByte <= busIn;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    hsfp_byte_t statusByte;

    always_comb begin
        statusByte = 8'h00;
        statusByte[`HSFP_ST_INREQ]    = inSvcReq;
        statusByte[`HSFP_ST_OUTREQ]   = outSvcReq;
        statusByte[`HSFP_ST_IMMOUT]   = immOutValid;
        statusByte[`HSFP_ST_DSCHEAD]  = dscAtHead;
        statusByte[`HSFP_ST_OUTEMPTY] = outFifoEmpty;
        statusByte[`HSFP_ST_INFULL]   = inFifoFull;
        statusByte[`HSFP_ST_DMAEN]    = hostDmaEn;
        statusByte[`HSFP_ST_ERR]      = errFlag;
    end

    // Byte is loaded once, as the read begins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostDataOut <= 8'h00;
        end else if (accState == HSFP_ACC_IDLE && rdActive) begin
            if (!dackN) begin
                hostDataOut <= outFifoData;
            end else begin
                case (addr)
                    `HSFP_ADDR_FIFO: hostDataOut <= outFifoData;
                    `HSFP_ADDR_IMM:  hostDataOut <= immOutData;
                    `HSFP_ADDR_CTRL: hostDataOut <= statusByte;
                    default:         hostDataOut <= `HSFP_UNMAPPED_RD;
                endcase
            end
        end
    end

    // Drive only during a qualified read
    assign hostDataOe = (accState == HSFP_ACC_READ) && rdActive;

    // Pop at the trailing edge so the head held steady
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outFifoPop <= 1'b0;
            immOutAck  <= 1'b0;
        end else begin
            outFifoPop <= rdEnd && !outFifoEmpty
                          && (accDack ? !outFifoCmd
                                      : accAddr == `HSFP_ADDR_FIFO);
            immOutAck  <= rdEnd && !accDack && accAddr == `HSFP_ADDR_IMM
                          && immOutValid;
        end
    end

    // ------------------------------------------------------------
    // Write targets
    // ------------------------------------------------------------
    logic fifoWrite;
    logic pushWanted;

    assign fifoWrite  = accDack || accAddr == `HSFP_ADDR_FIFO
                        || accAddr == `HSFP_ADDR_DSC;
    assign pushWanted = wrEnd && fifoWrite;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inFifoPush <= 1'b0;
            inFifoData <= 8'h00;
            inFifoCmd  <= 1'b0;
        end else begin
            inFifoPush <= pushWanted && !inFifoFull;
            if (pushWanted) begin
                inFifoData <= wrByte;
                // Acknowledged writes are always data
                inFifoCmd  <= !accDack && accAddr == `HSFP_ADDR_DSC;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            immInPush <= 1'b0;
            immInData <= 8'h00;
        end else begin
            immInPush <= wrEnd && !accDack && accAddr == `HSFP_ADDR_IMM;
            if (wrEnd && !accDack && accAddr == `HSFP_ADDR_IMM) begin
                immInData <= wrByte;
            end
        end
    end

    // Clear bit is a command, never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= `HSFP_CTRL_RESET;
        end else if (wrEnd && !accDack && accAddr == `HSFP_ADDR_CTRL) begin
            ctrl <= wrByte & ~(8'h01 << `HSFP_CTRL_ERRCLR);
        end
    end

    // ------------------------------------------------------------
    // Error flag
    // ------------------------------------------------------------
    logic errSet;
    logic errClr;

    // Overrun, underrun, DSC under acknowledge, or internal report
    assign errSet = errEvent
                    || (pushWanted && inFifoFull)
                    || (rdEnd && outFifoEmpty
                        && (accDack || accAddr == `HSFP_ADDR_FIFO))
                    || (rdEnd && accDack && dscAtHead);
    assign errClr = wrEnd && !accDack && accAddr == `HSFP_ADDR_CTRL
                    && wrByte[`HSFP_CTRL_ERRCLR];

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            errFlag <= 1'b0;
        end else if (errSet) begin
            errFlag <= 1'b1;
        end else if (errClr) begin
            errFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Request and interrupt lines
    // ------------------------------------------------------------
    logic outNeed;
    logic dscStop;

    assign dscStop = hostDmaEn && dscAtHead;
    assign outNeed = outSvcReq && !dscStop;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inXferDmaReq  <= 1'b0;
            outXferDmaReq <= 1'b0;
            hostIrq       <= 1'b0;
        end else begin
            inXferDmaReq  <= reqLinesEn && inSvcReq;
            outXferDmaReq <= reqLinesEn && outNeed;
            hostIrq       <= immOutValid || errFlag
                             || dscStop
                             || (!hostDmaEn && !reqLinesEn
                                 && (inSvcReq || outSvcReq));
        end
    end

endmodule

`default_nettype wire

// file: verilog/hsfp_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk; the output follows
 * once stages two and three agree.
 */
`timescale 1ns/1ns
`default_nettype none

module hsfp_pin_sync #(
    parameter int          W     = 1,
    parameter logic [W-1:0] RST_V = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // ------------------------------------------------------------
    // Stage chain
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= RST_V;
            stage2 <= RST_V;
            stage3 <= RST_V;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ------------------------------------------------------------
    // Agreement filter, per bit
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < W; b = b + 1) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pinOut[b] <= RST_V[b];
                end else if (stage2[b] == stage3[b]) begin
                    pinOut[b] <= stage3[b];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: verilog/hsfp_pkg.sv
/*
 * Types of the host slave FIFO port.
 * Assumes the constants header is on the include path.
 */
`default_nettype none

package hsfp_pkg;

// ----------------------------------------------------------------
// Host access sequencer
// ----------------------------------------------------------------
typedef enum logic [1:0] {
    HSFP_ACC_IDLE  = 2'b00,
    HSFP_ACC_READ  = 2'b01,
    HSFP_ACC_WRITE = 2'b10
} hsfp_acc_e;

typedef logic [7:0] hsfp_byte_t;

endpackage

`default_nettype wire
